//--- verilog/asitx_pkg.sv
// asitx_pkg: register map, field layout and frame constants of the transmit slot router
package asitx_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PIN_SELECT = 6'h1d;
	localparam logic [5:0] IDX_CHAN1_CFG = 6'h1e;
	localparam logic [5:0] IDX_CHAN2_CFG = 6'h1f;
	localparam logic [5:0] IDX_CONTROL = 6'h30;
	localparam logic [5:0] IDX_STATUS = 6'h31;

	localparam logic [7:0] RST_PIN_SELECT = 8'h00;
	localparam logic [5:0] RST_CHAN1_CFG = 6'h20;
	localparam logic [5:0] RST_CHAN2_CFG = 6'h21;
	localparam logic [4:0] RST_CONTROL = 5'h00;

	// channel config: bit 5 source enable, bits 4..0 slot index, bits 7..6 reserved
	localparam int unsigned CFG_W = 6;
	localparam int unsigned SRC_EN_BIT = 5;
	localparam int unsigned SLOT_W = 5;
	localparam logic [1:0] CFG_RSVD_READ = 2'h0;

	// control: bits 1..0 format, bit 2 unused cycle fill, bits 4..3 word length
	localparam int unsigned CTRL_W = 5;
	localparam int unsigned FMT_LSB = 0;
	localparam int unsigned FILL_BIT = 2;
	localparam int unsigned WLEN_LSB = 3;

	// status: bit 0 config pending, bits 15..8 frame count
	localparam int unsigned PENDING_BIT = 0;
	localparam int unsigned FCNT_LSB = 8;
	localparam int unsigned FCNT_W = 8;

	typedef enum logic [1:0] {
		ASITX_FMT_TDM = 2'b00,
		ASITX_FMT_I2S = 2'b01,
		ASITX_FMT_LJ = 2'b10,
		ASITX_FMT_RSVD = 2'b11
	} asitx_format_t;

	localparam logic [4:0] LAST_BIT_16 = 5'h0f;
	localparam logic [4:0] LAST_BIT_20 = 5'h13;
	localparam logic [4:0] LAST_BIT_24 = 5'h17;
	localparam logic [4:0] LAST_BIT_32 = 5'h1f;
	localparam logic [4:0] MSB_IDX = 5'h1f;

	localparam logic [5:0] TDM_SLOTS = 6'h20;
	localparam logic [5:0] HALF_SLOTS = 6'h10;
	localparam logic [5:0] SLOT_SAT = 6'h3f;

	localparam int unsigned NUM_CH = 8;
	localparam int unsigned MIC_CH = 2;
	localparam int unsigned SAMPLE_W = 32;

endpackage : asitx_pkg

//--- verilog/asitx_sync2.sv
// asitx_sync2: two-flop level synchroniser with asynchronous clear
`timescale 1ns/1ns
`default_nettype none
module asitx_sync2 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : asitx_sync2
`default_nettype wire

//--- verilog/asitx_slot_match.sv
// asitx_slot_match: decides whether one source channel owns the current bit and picks its bit
`timescale 1ns/1ns
`default_nettype none
module asitx_slot_match (
	input wire logic src_enable,
	input wire logic [4:0] slot_index,
	input wire logic [4:0] cur_index,
	input wire logic index_valid,
	input wire logic [4:0] bit_pos,
	input wire logic [31:0] sample,
	output logic active,
	output logic data_bit
);
	logic [4:0] sel;

	// a disabled source never claims the slot, so the pin stays free
	assign active = src_enable & index_valid & (slot_index == cur_index); // [RQ4] [RQ5] [RQ6]
	// samples are left-aligned, sent msb first
	assign sel = asitx_pkg::MSB_IDX - bit_pos;
	assign data_bit = sample[sel];
endmodule : asitx_slot_match
`default_nettype wire

//--- verilog/asitx_router.sv
// asitx_router: transmit channel pin, source and slot routing with apb registers
//
// Functional notes
// RQ1 - channels 1-4 go to primary data pin when select bit 0, else secondary
// RQ2 - channels 5-8 go to primary data pin when select bit 0, else secondary
// RQ3 - pin select register resets to zero, all channels on primary pin
// RQ4 - channel 1 source enable low tri-states it, high sends microphone 1
// RQ5 - channel 2 source enable low tri-states it, high sends microphone 2
// RQ6 - five-bit slot field; in tdm the channel takes slot equal to field
// RQ7 - in i2s or lj, values 0-15 map to left slots 0-15
// RQ8 - in i2s or lj, values 16-31 map to right slots 0-15
// RQ9 - channel 1 config resets to 0x20: source on, slot 0
// RQ10 - channel 2 config resets to 0x21: source on, slot 1
// RQ11 - software writes zero to reserved bits 7-6; they read zero
// RQ12 - bit cycles with no channel drive zero or high impedance per fill
// RQ13 - same pin, same slot conflict: lowest channel number wins
// RQ14 - routing, source and slot changes apply only at frame start
`timescale 1ns/1ns
`default_nettype none
module asitx_router (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bit_clk,
	input wire logic frame_sync,
	input wire logic [31:0] mic1_sample,
	input wire logic [31:0] mic2_sample,
	input wire logic [5:0] other_chan_active,
	input wire logic [5:0] other_chan_bit,
	output logic primary_data_out,
	output logic primary_data_oe,
	output logic secondary_data_out,
	output logic secondary_data_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [4:0] last_bit_of(input logic [1:0] wlen);
		case (wlen)
			2'h0: last_bit_of = asitx_pkg::LAST_BIT_16;
			2'h1: last_bit_of = asitx_pkg::LAST_BIT_20;
			2'h2: last_bit_of = asitx_pkg::LAST_BIT_24;
			default: last_bit_of = asitx_pkg::LAST_BIT_32;
		endcase
	endfunction : last_bit_of

	// returns {hit, bit}; lowest channel number wins a shared slot
	function automatic logic [1:0] pick_lowest(input logic [7:0] act, input logic [7:0] bits);
		logic [1:0] r;
		r = 2'h0;
		for (int i = asitx_pkg::NUM_CH - 1; i >= 0; i--)
		begin
			if (act[i])
				r = {1'b1, bits[i]}; // [RQ13]
		end
		pick_lowest = r;
	endfunction : pick_lowest

	////////////////////////////////////////////////////////////////////////////////
	// apb register file (mclk)

	logic [7:0] pin_select;
	logic [5:0] chan1_cfg;
	logic [5:0] chan2_cfg;
	logic [4:0] control;
	logic cfg_dirty;
	logic xfer_busy;
	logic xfer_req;
	logic [7:0] xfer_pin;
	logic [5:0] xfer_ch1;
	logic [5:0] xfer_ch2;
	logic [4:0] xfer_ctrl;
	logic ack_in_mclk;
	logic frame_tgl_mclk;
	logic frame_tgl_seen;
	logic [7:0] frame_count;

	wire logic [5:0] reg_idx = paddr[7:2];
	wire logic hit_pin = (reg_idx == asitx_pkg::IDX_PIN_SELECT);
	wire logic hit_ch1 = (reg_idx == asitx_pkg::IDX_CHAN1_CFG);
	wire logic hit_ch2 = (reg_idx == asitx_pkg::IDX_CHAN2_CFG);
	wire logic hit_ctrl = (reg_idx == asitx_pkg::IDX_CONTROL);
	wire logic hit_stat = (reg_idx == asitx_pkg::IDX_STATUS);
	wire logic addr_hit = (paddr[1:0] == 2'h0) & (hit_pin | hit_ch1 | hit_ch2 | hit_ctrl | hit_stat);
	wire logic wr_en = psel & penable & pwrite & addr_hit;
	wire logic cfg_write = wr_en & (hit_pin | hit_ch1 | hit_ch2 | hit_ctrl);
	wire logic cfg_pending = cfg_dirty | xfer_busy;

	wire logic [31:0] rd_pin = {24'h000000, pin_select};
	// reserved upper bits are never stored, so they always read zero
	wire logic [31:0] rd_ch1 = {24'h000000, asitx_pkg::CFG_RSVD_READ, chan1_cfg}; // [RQ11]
	wire logic [31:0] rd_ch2 = {24'h000000, asitx_pkg::CFG_RSVD_READ, chan2_cfg}; // [RQ11]
	wire logic [31:0] rd_ctrl = {27'h0000000, control};
	wire logic [31:0] rd_stat = {16'h0000, frame_count, 7'h00, cfg_pending};
	wire logic [31:0] rd_mux = hit_pin ? rd_pin :
		hit_ch1 ? rd_ch1 :
		hit_ch2 ? rd_ch2 :
		hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat : 32'h00000000;

	// zero wait states; a bad address still completes, flagged by pslverr
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			prdata <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			prdata <= addr_hit ? rd_mux : 32'h00000000;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_select <= asitx_pkg::RST_PIN_SELECT; // [RQ3]
			chan1_cfg <= asitx_pkg::RST_CHAN1_CFG; // [RQ9]
			chan2_cfg <= asitx_pkg::RST_CHAN2_CFG; // [RQ10]
			control <= asitx_pkg::RST_CONTROL;
		end
		else if (wr_en)
		begin
			if (hit_pin)
				pin_select <= pwdata[7:0];
			if (hit_ch1)
				chan1_cfg <= pwdata[asitx_pkg::CFG_W-1:0];
			if (hit_ch2)
				chan2_cfg <= pwdata[asitx_pkg::CFG_W-1:0];
			if (hit_ctrl)
				control <= pwdata[asitx_pkg::CTRL_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// config hand-over to the link domain: toggle request, toggle acknowledge
	// xfer_* stay frozen while busy, so the link side may sample them at any time

	wire logic start_xfer = cfg_dirty & ~xfer_busy;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_dirty <= 1'b0;
			xfer_busy <= 1'b0;
			xfer_req <= 1'b0;
			xfer_pin <= asitx_pkg::RST_PIN_SELECT;
			xfer_ch1 <= asitx_pkg::RST_CHAN1_CFG;
			xfer_ch2 <= asitx_pkg::RST_CHAN2_CFG;
			xfer_ctrl <= asitx_pkg::RST_CONTROL;
		end
		else
		begin
			// a write in the launch cycle keeps dirty set and goes next round
			cfg_dirty <= cfg_write | (cfg_dirty & ~start_xfer);
			if (start_xfer)
			begin
				xfer_pin <= pin_select;
				xfer_ch1 <= chan1_cfg;
				xfer_ch2 <= chan2_cfg;
				xfer_ctrl <= control;
				xfer_req <= ~xfer_req;
				xfer_busy <= 1'b1;
			end
			else if (ack_in_mclk == xfer_req)
				xfer_busy <= 1'b0;
		end
	end

	// frame counter fed by a toggle from the link side
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			frame_tgl_seen <= 1'b0;
			frame_count <= 8'h00;
		end
		else
		begin
			frame_tgl_seen <= frame_tgl_mclk;
			if (frame_tgl_mclk != frame_tgl_seen)
				frame_count <= frame_count + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// link domain (bit_clk)

	logic link_rst_n;
	logic req_in_link;
	logic ack_tgl;
	logic frame_tgl;
	logic [7:0] act_pin;
	logic [5:0] act_cfg [asitx_pkg::MIC_CH];
	logic [4:0] act_ctrl;
	logic fs_q;
	logic fs_q2;
	logic running;
	logic half;
	logic [4:0] bit_cnt;
	logic [5:0] slot_cnt;
	logic [31:0] mic_hold [asitx_pkg::MIC_CH];

	asitx_sync2 u_link_rst (.clk(bit_clk), .rst_n(resetn), .d(1'b1), .q(link_rst_n));
	asitx_sync2 u_req_sync (.clk(bit_clk), .rst_n(link_rst_n), .d(xfer_req), .q(req_in_link));
	asitx_sync2 u_ack_sync (.clk(mclk), .rst_n(resetn), .d(ack_tgl), .q(ack_in_mclk));
	asitx_sync2 u_frame_sync (.clk(mclk), .rst_n(resetn), .d(frame_tgl), .q(frame_tgl_mclk));

	wire asitx_pkg::asitx_format_t fmt = asitx_pkg::asitx_format_t'(act_ctrl[asitx_pkg::FMT_LSB +: 2]);
	wire logic is_tdm = (fmt == asitx_pkg::ASITX_FMT_TDM);
	wire logic is_i2s = (fmt == asitx_pkg::ASITX_FMT_I2S);
	wire logic fill_hiz = act_ctrl[asitx_pkg::FILL_BIT];
	wire logic [4:0] last_bit = last_bit_of(act_ctrl[asitx_pkg::WLEN_LSB +: 2]);

	// i2s halves start one bit clock after the frame sync edge
	wire logic raw_rise = frame_sync & ~fs_q;
	wire logic raw_fall = ~frame_sync & fs_q;
	wire logic dly_rise = fs_q & ~fs_q2;
	wire logic dly_fall = ~fs_q & fs_q2;
	wire logic left_start = is_i2s ? dly_fall : raw_rise;
	wire logic right_start = ~is_tdm & (is_i2s ? dly_rise : raw_fall);
	wire logic cfg_take = left_start & (req_in_link != ack_tgl);

	always_ff @(posedge bit_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			fs_q <= 1'b0;
			fs_q2 <= 1'b0;
		end
		else
		begin
			fs_q <= frame_sync;
			fs_q2 <= fs_q;
		end
	end

	// new settings land only on a frame's first bit, never mid-slot
	always_ff @(posedge bit_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			ack_tgl <= 1'b0;
			act_pin <= asitx_pkg::RST_PIN_SELECT;
			act_cfg[0] <= asitx_pkg::RST_CHAN1_CFG;
			act_cfg[1] <= asitx_pkg::RST_CHAN2_CFG;
			act_ctrl <= asitx_pkg::RST_CONTROL;
		end
		else if (cfg_take)
		begin
			ack_tgl <= req_in_link; // [RQ14]
			act_pin <= xfer_pin; // [RQ14]
			act_cfg[0] <= xfer_ch1; // [RQ14]
			act_cfg[1] <= xfer_ch2; // [RQ14]
			act_ctrl <= xfer_ctrl; // [RQ14]
		end
	end

	wire logic [5:0] next_slot = (slot_cnt == asitx_pkg::SLOT_SAT) ? slot_cnt : slot_cnt + 6'h01;

	always_ff @(posedge bit_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			running <= 1'b0;
			half <= 1'b0;
			bit_cnt <= 5'h00;
			slot_cnt <= 6'h00;
			frame_tgl <= 1'b0;
		end
		else if (left_start | right_start)
		begin
			running <= 1'b1;
			half <= right_start;
			bit_cnt <= 5'h00;
			slot_cnt <= 6'h00;
			if (left_start)
				frame_tgl <= ~frame_tgl;
		end
		else if (bit_cnt == last_bit)
		begin
			bit_cnt <= 5'h00;
			slot_cnt <= next_slot;
		end
		else
			bit_cnt <= bit_cnt + 5'h01;
	end

	// samples are held for the whole frame
	always_ff @(posedge bit_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			mic_hold[0] <= 32'h00000000;
			mic_hold[1] <= 32'h00000000;
		end
		else if (left_start)
		begin
			mic_hold[0] <= mic1_sample;
			mic_hold[1] <= mic2_sample;
		end
	end

	// the right half restarts the slot count with the half flag as index bit 4
	wire logic [4:0] cur_index = is_tdm ? slot_cnt[4:0] : {half, slot_cnt[3:0]}; // [RQ6] [RQ7] [RQ8]
	wire logic index_valid = running & (is_tdm ? (slot_cnt < asitx_pkg::TDM_SLOTS) :
		(slot_cnt < asitx_pkg::HALF_SLOTS)); // [RQ7] [RQ8]

	////////////////////////////////////////////////////////////////////////////////
	// channel sources and pin routing

	logic [7:0] chan_active;
	logic [7:0] chan_bit;

	genvar g;
	generate
		for (g = 0; g < asitx_pkg::MIC_CH; g++)
		begin : g_mic
			asitx_slot_match u_match (.src_enable(act_cfg[g][asitx_pkg::SRC_EN_BIT]),
				.slot_index(act_cfg[g][asitx_pkg::SLOT_W-1:0]), .cur_index(cur_index), .index_valid(index_valid),
				.bit_pos(bit_cnt), .sample(mic_hold[g]), .active(chan_active[g]), .data_bit(chan_bit[g]));
		end
	endgenerate

	// channels 3 to 8 are timed by the rest of the port; only their pin is chosen here
	assign chan_active[7:2] = other_chan_active;
	assign chan_bit[7:2] = other_chan_bit;

	wire logic [7:0] to_primary = chan_active & ~act_pin; // [RQ1] [RQ2]
	wire logic [7:0] to_secondary = chan_active & act_pin; // [RQ1] [RQ2]
	wire logic [1:0] pick_p = pick_lowest(to_primary, chan_bit);
	wire logic [1:0] pick_s = pick_lowest(to_secondary, chan_bit);

	always_ff @(posedge bit_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			primary_data_out <= 1'b0;
			primary_data_oe <= 1'b0;
			secondary_data_out <= 1'b0;
			secondary_data_oe <= 1'b0;
		end
		else
		begin
			primary_data_out <= pick_p[1] & pick_p[0];
			primary_data_oe <= pick_p[1] | ~fill_hiz; // [RQ12]
			secondary_data_out <= pick_s[1] & pick_s[0];
			secondary_data_oe <= pick_s[1] | ~fill_hiz; // [RQ12]
		end
	end

endmodule : asitx_router
`default_nettype wire

//--- sim/asitx_router_props.sv
// asitx_router_props: apb-side assertions of the transmit slot router
`timescale 1ns/1ns
`default_nettype none
module asitx_router_props (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic [7:0] sel_shadow;
	wire acc = psel && penable;
	wire mapped = paddr inside {8'h74, 8'h78, 8'h7c, 8'hc0, 8'hc4};
	wire rd_acc = acc && !pwrite;
	wire cfg_rd = rd_acc && (paddr == 8'h78 || paddr == 8'h7c);

	// shadow of the pin select register, written only on a completed access
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			sel_shadow <= 8'h00;
		else if (acc && pwrite && paddr == 8'h74)
			sel_shadow <= pwdata[7:0];

	////////////////////////////////////////////////////////////////
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	property p_ready;
		s_setup ##1 s_access |-> pready;
	endproperty
	property p_err_bad;
		s_access and acc && !mapped |-> pslverr;
	endproperty
	property p_err_good;
		acc && mapped |-> !pslverr;
	endproperty
	property p_err_idle;
		!acc |-> !pslverr;
	endproperty
	property p_bad_zero;
		rd_acc && !mapped |-> prdata == 32'h0;
	endproperty
	property p_cfg_rsvd;
		cfg_rd |-> prdata[31:6] == 26'h0;
	endproperty
	property p_sel_read;
		rd_acc && paddr == 8'h74 |-> prdata == {24'h0, sel_shadow};
	endproperty
	property p_prdata_hold;
		!(psel && !penable) |=> $stable(prdata);
	endproperty
	property p_upper_zero;
		rd_acc && mapped |-> prdata[31:16] == 16'h0;
	endproperty

	a_ready: assert property (p_ready) else $error("access phase without ready");
	a_err_bad: assert property (p_err_bad) else $error("bad address not refused");
	a_err_good: assert property (p_err_good) else $error("good address refused");
	a_err_idle: assert property (p_err_idle) else $error("error outside access");
	a_bad_zero: assert property (p_bad_zero) else $error("refused read not zero");
	a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved bits set");
	a_sel_read: assert property (p_sel_read) else $error("pin select readback");
	a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
endmodule : asitx_router_props

bind asitx_router asitx_router_props asitx_router_props_inst (.*);
`default_nettype wire

//--- sim/asitx_host_model.sv
// asitx_host_model: serial audio receiver making bit clock and frame sync, recording both pins
`timescale 1ns/1ns
`default_nettype none
module asitx_host_model (
	output logic bit_clk,
	output logic frame_sync,
	input wire logic [1:0] fmt,
	input wire logic primary_data_out,
	input wire logic primary_data_oe,
	input wire logic secondary_data_out,
	input wire logic secondary_data_oe
);
	localparam int FBITS = 512;
	logic cap_p [0:FBITS-1];
	logic cap_s [0:FBITS-1];
	// a released pin floats, so a stale level never passes for data
	wire pri_pin = primary_data_oe ? primary_data_out : 1'bz;
	wire sec_pin = secondary_data_oe ? secondary_data_out : 1'bz;

	function automatic logic fs_at(input int b);
		case (fmt)
			2'b00: return b == 0;
			2'b01: return b >= FBITS / 2;
			default: return b < FBITS / 2;
		endcase
	endfunction : fs_at

	initial
	begin
		bit_clk = 1'b0;
		frame_sync = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// clock runs only in a burst; pins sampled mid-bit, last frame kept
	task automatic run(input int frames);
		int dly;
		// registered pin: bit 0 shows two bit clocks after the frame edge, one more in i2s
		dly = (fmt == 2'b01) ? 3 : 2;
		#7;
		for (int t = -8; t < frames * FBITS + dly; t++)
		begin
			frame_sync = fs_at(t < 0 ? FBITS - 1 : t % FBITS);
			if (t >= dly)
			begin
				cap_p[(t - dly) % FBITS] = pri_pin;
				cap_s[(t - dly) % FBITS] = sec_pin;
			end
			#80 bit_clk = 1'b1;
			#80 bit_clk = 1'b0;
		end
	endtask : run
endmodule : asitx_host_model
`default_nettype wire

//--- sim/asi_tx_channel_slot_router_tb.sv
// asi_tx_channel_slot_router_tb: self-checking bench for the transmit slot router
`timescale 1ns/1ns
`default_nettype none
module asi_tx_channel_slot_router_tb;
	logic mclk = 1'b0;
	logic resetn;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire bit_clk;
	wire frame_sync;
	logic [31:0] mic1_sample = 32'h0;
	logic [31:0] mic2_sample = 32'h0;
	logic [5:0] other_chan_active = 6'h00;
	logic [5:0] other_chan_bit = 6'h00;
	wire primary_data_out;
	wire primary_data_oe;
	wire secondary_data_out;
	wire secondary_data_oe;
	logic [7:0] ctrl = 8'h00;
	logic [7:0] sel = 8'h00;
	logic [7:0] cfg1;
	logic [7:0] cfg2;
	logic [7:0] oa;
	logic [7:0] ob;
	wire [1:0] fmt = ctrl[1:0];
	logic [31:0] seed = 32'hdc94f7cc;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int checks = 0;
	// ctrl, pin select, cfg1, cfg2, other active, other bit
	localparam logic [47:0] CASES [5] = '{48'h08_00_20_21_00_00, 48'h04_03_3f_1f_01_01,
		48'h01_f0_2f_30_24_04, 48'h1f_01_30_00_00_00, 48'h10_00_25_25_00_00};

	always #10 mclk = ~mclk;

	asitx_router asitx_router_inst (.*);
	asitx_host_model asitx_host_model_inst (.*);

	////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic chk_w(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk_w

	task automatic chk_b(input string s, input logic e, input logic g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %b seen %b", s, e, g);
		end
	endtask : chk_b

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			err_count++;
			end_sim();
		end
	endtask : apb

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// slot width follows the word length field; lowest channel number wins a shared slot
	function automatic logic exp_bit(input int p, input int b);
		int w;
		int h;
		int pos;
		int sl;
		logic [7:0] c;
		w = ctrl[4:3] == 2'h3 ? 32 : 16 + 4 * ctrl[4:3];
		h = fmt == 2'b00 ? 0 : b / 256;
		pos = fmt == 2'b00 ? b : b % 256;
		sl = pos / w;
		for (int i = 0; i < 8; i++)
		begin
			c = i == 0 ? cfg1 : cfg2;
			if (sel[i] == p && (i > 1 ? other_chan_active[i - 2] :
				c[5] && (fmt == 2'b00 ? c[4:0] == sl : c[4] == h && c[3:0] == sl)))
				return i == 0 ? mic1_sample[31 - pos % w] : i == 1 ? mic2_sample[31 - pos % w] : other_chan_bit[i - 2];
		end
		return ctrl[2] ? 1'bz : 1'b0;
	endfunction : exp_bit

	////////////////////////////////////////////////////////////////
	initial
	begin
		// leaving x for zero gives the asynchronous clears a falling edge
		resetn <= 1'b0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		asitx_host_model_inst.run(0);
		apb(1'b0, 8'h74, 32'h0);
		chk_w("pin select", 32'h00, rd);
		apb(1'b0, 8'h78, 32'h0);
		chk_w("chan1 cfg", 32'h20, rd);
		apb(1'b0, 8'h7c, 32'h0);
		chk_w("chan2 cfg", 32'h21, rd);
		apb(1'b1, 8'h78, 32'h00000031);
		apb(1'b0, 8'h78, 32'h0);
		chk_w("chan1 cfg", 32'h31, rd);
		apb(1'b0, 8'h80, 32'h0);
		chk_b("unmapped error", 1'b1, er);
		chk_w("unmapped data", 32'h0, rd);
		apb(1'b0, 8'h75, 32'h0);
		chk_b("unaligned error", 1'b1, er);
		$display("test registers done");
		for (int i = 0; i < 5; i++)
		begin
			{ctrl, sel, cfg1, cfg2, oa, ob} = CASES[i];
			apb(1'b1, 8'hc0, {24'h0, ctrl});
			seed = lfsr(seed);
			mic1_sample <= seed;
			mic2_sample <= ~seed;
			other_chan_active <= oa[5:0];
			other_chan_bit <= ob[5:0];
			apb(1'b1, 8'h74, {24'h0, sel});
			apb(1'b1, 8'h78, {24'h0, cfg1});
			apb(1'b1, 8'h7c, {24'h0, cfg2});
			apb(1'b0, 8'h7c, 32'h0);
			chk_w("chan2 cfg", {24'h0, cfg2}, rd);
			apb(1'b0, 8'hc0, 32'h0);
			chk_w("control", {24'h0, ctrl}, rd);
			apb(1'b0, 8'hc4, 32'h0);
			chk_b("pending", 1'b1, rd[0]);
			asitx_host_model_inst.run(2);
			apb(1'b0, 8'hc4, 32'h0);
			chk_b("pending", 1'b0, rd[0]);
			for (int b = 0; b < 512; b++)
			begin
				chk_b("primary pin", exp_bit(0, b), asitx_host_model_inst.cap_p[b]);
				chk_b("secondary pin", exp_bit(1, b), asitx_host_model_inst.cap_s[b]);
			end
			$display("test frame %0d done", i);
		end
		end_sim();
	end
endmodule : asi_tx_channel_slot_router_tb
`default_nettype wire
